/* File: design/dwe_pkg.sv */
//------------------------------------------------------------
//------------------------------------------------------------
package dwe_pkg;
  localparam int DEPTH = 4;
  localparam int AW    = 2;
  localparam int IDW   = 4;
  localparam int SQW   = 4;
  localparam logic [2:0] BEATS_BURST  = 3'h4;
  localparam logic [2:0] BEATS_SINGLE = 3'h1;
  localparam logic [AW:0] CNT_FULL    = 3'h4;

  typedef struct packed {
    logic           burst;
    logic [IDW-1:0] id;
    logic [SQW-1:0] seq;
  } dwe_ent_s;

  typedef enum logic {MODE_NORMAL, MODE_STREAM} dwe_mode_e;
  typedef enum logic [1:0] {K_READ, K_WRITE, K_PUSH} dwe_kind_e;
  typedef enum logic {A_IDLE, A_BUSY} dwe_astate_e;
  typedef enum logic [1:0] {D_IDLE, D_WR, D_RD} dwe_dstate_e;
endpackage : dwe_pkg

/* File: design/dwe_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module dwe_mem
  import dwe_pkg::*;
(
  input  wire logic          mclk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire dwe_ent_s      wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output dwe_ent_s           rdata_o
);
  dwe_ent_s mem_r [DEPTH];

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // Bypass keeps a write into an empty queue visible next cycle
  always_ff @(posedge mclk_i) begin
    if (we_i && (waddr_i == raddr_i)) begin
      rdata_o <= wdata_i;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule : dwe_mem
`default_nettype wire

/* File: design/dwe_top.sv */
`timescale 1ns/100ps
`default_nettype none
module dwe_top
  import dwe_pkg::*;
(
  input  wire logic           mclk_i,
  input  wire logic           rstn_i,
  input  wire logic           data_retry_in_n_i,
  input  wire logic           address_grant_in_i,
  input  wire logic           addr_ack_i,
  input  wire logic           address_retry_i,
  input  wire logic           data_grant_in_i,
  input  wire logic           write_first_qualifier_i,
  input  wire logic           data_busy_in_i,
  input  wire logic           transfer_ack_i,
  input  wire logic           rd_req_i,
  input  wire logic [IDW-1:0] rd_id_i,
  input  wire logic           rd_burst_i,
  input  wire logic           wr_req_i,
  input  wire logic [IDW-1:0] wr_id_i,
  input  wire logic           wr_burst_i,
  input  wire logic           push_req_i,
  input  wire logic [IDW-1:0] push_id_i,
  input  wire logic           push_burst_i,
  output logic                addr_busy_o,
  output dwe_kind_e           addr_kind_o,
  output logic [IDW-1:0]      addr_id_o,
  output logic                rd_taken_o,
  output logic                wr_taken_o,
  output logic                push_taken_o,
  output logic                data_busy_out_o,
  output logic                data_busy_oe_o,
  output logic                wr_drive_o,
  output logic                rd_latch_o,
  output logic [IDW-1:0]      data_id_o,
  output dwe_mode_e           stream_mode_o
);
  //----------------------------------------------------------
  // Mode strap
  //----------------------------------------------------------
  logic      rty_s1_r;
  logic      rty_s2_r;
  logic      in_reset_r;

  always_ff @(posedge mclk_i) begin
    rty_s1_r <= data_retry_in_n_i;
    rty_s2_r <= rty_s1_r;
  end

  always_ff @(posedge mclk_i) begin
    in_reset_r <= !rstn_i;
  end

  // Synchroniser lag keeps the in-reset level at the release edge
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      stream_mode_o <= MODE_NORMAL;
    end else if (in_reset_r) begin
      stream_mode_o <= rty_s2_r ? MODE_NORMAL : MODE_STREAM;
    end
  end

  //----------------------------------------------------------
  // Address tenures
  //----------------------------------------------------------
  dwe_astate_e astate_r;
  dwe_ent_s    aent_r;
  logic [SQW-1:0] seq_r;
  logic        any_req;
  logic        a_done;
  logic        rq_push;
  logic        wq_push;
  logic [AW:0] rcnt_r;
  logic [AW:0] wcnt_r;

  assign any_req = rd_req_i || wr_req_i || push_req_i;
  assign a_done  = (astate_r == A_BUSY) && addr_ack_i && !address_retry_i;
  assign rq_push = a_done && (addr_kind_o == K_READ);
  assign wq_push = a_done && (addr_kind_o != K_READ);

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      astate_r    <= A_IDLE;
      addr_kind_o <= K_READ;
      aent_r      <= '0;
      addr_busy_o <= 1'b0;
    end else if (astate_r == A_IDLE) begin
      if (address_grant_in_i && any_req) begin
        astate_r    <= A_BUSY;
        addr_busy_o <= 1'b1;
        // Push-out chosen first here, ahead of a write, not at the data grant
        if (push_req_i) begin
          addr_kind_o <= K_PUSH;
          aent_r      <= '{burst: push_burst_i, id: push_id_i, seq: seq_r};
        end else if (wr_req_i) begin
          addr_kind_o <= K_WRITE;
          aent_r      <= '{burst: wr_burst_i, id: wr_id_i, seq: seq_r};
        end else begin
          addr_kind_o <= K_READ;
          aent_r      <= '{burst: rd_burst_i, id: rd_id_i, seq: seq_r};
        end
      end
    end else if (addr_ack_i) begin
      // Retried tenure leaves the request pending
      astate_r    <= A_IDLE;
      addr_busy_o <= 1'b0;
    end
  end

  assign addr_id_o = aent_r.id;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      seq_r <= '0;
    end else if (a_done) begin
      seq_r <= seq_r + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rd_taken_o   <= 1'b0;
      wr_taken_o   <= 1'b0;
      push_taken_o <= 1'b0;
    end else begin
      rd_taken_o   <= rq_push;
      wr_taken_o   <= a_done && (addr_kind_o == K_WRITE);
      push_taken_o <= a_done && (addr_kind_o == K_PUSH);
    end
  end

  //----------------------------------------------------------
  // Pending data tenure queues
  //----------------------------------------------------------
  dwe_dstate_e dstate_r;
  logic [2:0]  beats_r;
  logic [AW-1:0] r_wp_r;
  logic [AW-1:0] r_rp_r;
  logic [AW-1:0] w_wp_r;
  logic [AW-1:0] w_rp_r;
  dwe_ent_s    rhead;
  dwe_ent_s    whead;
  logic        rd_valid;
  logic        wr_valid;
  logic        qual;
  logic        rd_older;
  logic        sel_wr;
  logic        rq_pop;
  logic        wq_pop;
  logic        rq_wr;
  logic        wq_wr;
  logic [SQW-1:0] age;

  assign rd_valid = (rcnt_r != '0);
  assign wr_valid = (wcnt_r != '0);
  assign age      = rhead.seq - whead.seq;
  assign rd_older = age[SQW-1];
  // Streaming mode never looks at the busy line
  assign qual = data_grant_in_i && (dstate_r == D_IDLE) &&
                ((stream_mode_o == MODE_STREAM) || !data_busy_in_i);
  // Write-first only pulls a write ahead of a read
  assign sel_wr = wr_valid &&
                  (write_first_qualifier_i || !rd_valid || !rd_older);
  assign wq_pop = qual && sel_wr;
  assign rq_pop = qual && !sel_wr && rd_valid;
  // Full queue drops the entry, so its pointers must not move either
  assign rq_wr  = rq_push && (rcnt_r != CNT_FULL);
  assign wq_wr  = wq_push && (wcnt_r != CNT_FULL);

  dwe_mem u_rq (
    .mclk_i  (mclk_i),
    .we_i    (rq_wr),
    .waddr_i (r_wp_r),
    .wdata_i (aent_r),
    .raddr_i (rq_pop ? r_rp_r + 1'b1 : r_rp_r),
    .rdata_o (rhead)
  );

  // Write queue is strict FIFO: no write overtakes another
  dwe_mem u_wq (
    .mclk_i  (mclk_i),
    .we_i    (wq_wr),
    .waddr_i (w_wp_r),
    .wdata_i (aent_r),
    .raddr_i (wq_pop ? w_rp_r + 1'b1 : w_rp_r),
    .rdata_o (whead)
  );

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      r_wp_r <= '0;
      r_rp_r <= '0;
      rcnt_r <= '0;
    end else begin
      r_wp_r <= r_wp_r + AW'(rq_wr);
      r_rp_r <= r_rp_r + AW'(rq_pop);
      rcnt_r <= rcnt_r + (AW+1)'(rq_wr) - (AW+1)'(rq_pop);
    end
  end

  // Several writes may sit between a read's address and data
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      w_wp_r <= '0;
      w_rp_r <= '0;
      wcnt_r <= '0;
    end else begin
      w_wp_r <= w_wp_r + AW'(wq_wr);
      w_rp_r <= w_rp_r + AW'(wq_pop);
      wcnt_r <= wcnt_r + (AW+1)'(wq_wr) - (AW+1)'(wq_pop);
    end
  end

  //----------------------------------------------------------
  // Data tenures
  //----------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      dstate_r        <= D_IDLE;
      beats_r         <= '0;
      data_busy_out_o <= 1'b0;
      data_busy_oe_o  <= 1'b0;
      wr_drive_o      <= 1'b0;
      data_id_o       <= '0;
    end else begin
      case (dstate_r)
        D_IDLE: begin
          if (wq_pop || rq_pop) begin
            dstate_r        <= wq_pop ? D_WR : D_RD;
            beats_r         <= (wq_pop ? whead.burst : rhead.burst) ?
                               BEATS_BURST : BEATS_SINGLE;
            data_id_o       <= wq_pop ? whead.id : rhead.id;
            data_busy_out_o <= 1'b1;
            data_busy_oe_o  <= 1'b1;
            wr_drive_o      <= wq_pop;
          end
        end
        D_WR, D_RD: begin
          if (transfer_ack_i) begin
            beats_r <= beats_r - 1'b1;
            if (beats_r == BEATS_SINGLE) begin
              dstate_r        <= D_IDLE;
              data_busy_out_o <= 1'b0;
              data_busy_oe_o  <= 1'b0;
              wr_drive_o      <= 1'b0;
            end
          end
        end
        default: begin
          dstate_r <= D_IDLE;
        end
      endcase
    end
  end

  // Envelope open: a write went ahead of an older pending read
  logic env_r;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      env_r <= 1'b0;
    end else if (rq_pop) begin
      env_r <= 1'b0;
    end else if (wq_pop && rd_valid && rd_older) begin
      env_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rd_latch_o <= 1'b0;
    end else begin
      rd_latch_o <= (dstate_r == D_RD) && transfer_ack_i;
    end
  end

  //----------------------------------------------------------
  // Checks
  //----------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_wr_end;
    (dstate_r == D_WR) && transfer_ack_i && (beats_r == BEATS_SINGLE);
  endsequence
  sequence s_rd_grant;
    env_r && qual && !write_first_qualifier_i;
  endsequence

  property p_mode_cap;
    in_reset_r |=> stream_mode_o ==
      ($past(rty_s2_r) ? MODE_NORMAL : MODE_STREAM);
  endproperty
  a_mode_cap: assert property (p_mode_cap)
    else $error("mode not taken from retry at release");

  property p_mode_hold;
    !in_reset_r |=> $stable(stream_mode_o);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed outside reset");

  property p_busy_ignored;
    (stream_mode_o == MODE_STREAM) && data_grant_in_i &&
    (dstate_r == D_IDLE) && (rd_valid || wr_valid) |=> dstate_r != D_IDLE;
  endproperty
  a_busy_ignored: assert property (p_busy_ignored)
    else $error("streaming grant not taken");

  property p_in_order;
    qual && !write_first_qualifier_i && rd_valid && rd_older
    |=> dstate_r == D_RD;
  endproperty
  a_in_order: assert property (p_in_order)
    else $error("older read not served first");

  property p_wf;
    qual && write_first_qualifier_i && wr_valid |=> dstate_r == D_WR;
  endproperty
  a_wf: assert property (p_wf)
    else $error("write-first did not run a write");

  property p_wr_fifo;
    wq_pop |=> data_id_o == $past(whead.id);
  endproperty
  a_wr_fifo: assert property (p_wr_fifo)
    else $error("write served out of queue order");

  property p_busy_wr;
    wq_pop |=> data_busy_out_o && wr_drive_o ##0 (dstate_r == D_WR);
  endproperty
  a_busy_wr: assert property (p_busy_wr)
    else $error("busy or drive missing on write");

  property p_busy_end;
    s_wr_end |=> !data_busy_out_o && !wr_drive_o;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy not negated at write end");

  property p_finish_read;
    s_rd_grant |=> (dstate_r == D_RD) ##[1:300] rd_latch_o;
  endproperty
  a_finish_read: assert property (p_finish_read)
    else $error("read not completed after envelope");

  property p_no_read;
    qual && write_first_qualifier_i && !rd_valid && wr_valid
    |=> data_id_o == $past(whead.id);
  endproperty
  a_no_read: assert property (p_no_read)
    else $error("write order changed without read");

  property p_push_first;
    (astate_r == A_IDLE) && address_grant_in_i && push_req_i
    |=> addr_kind_o == K_PUSH && addr_busy_o;
  endproperty
  a_push_first: assert property (p_push_first)
    else $error("push-out not chosen at address grant");
endmodule : dwe_top
`default_nettype wire

/* File: test/dwe_arb_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dwe_arb_model (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  input  wire logic agen_i,
  input  wire logic retry_i,
  input  wire logic addr_busy_i,
  input  wire logic taken_i,
  input  wire logic data_busy_i,
  output logic      address_grant_o,
  output logic      addr_ack_o,
  output logic      address_retry_o,
  output logic      transfer_ack_o
);
  //----------------------------------------
  // Arbiter and slave side
  //----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      address_grant_o <= 1'b0;
      addr_ack_o      <= 1'b0;
      address_retry_o <= 1'b0;
      transfer_ack_o  <= 1'b0;
    end else begin
      // Grant off around the taken pulse, no duplicate tenure
      address_grant_o <= agen_i & !addr_busy_i & !taken_i;
      addr_ack_o      <= addr_busy_i & !addr_ack_o;
      address_retry_o <= addr_busy_i & !addr_ack_o & retry_i;
      // Slow slave: one beat every other cycle
      transfer_ack_o  <= data_busy_i & !transfer_ack_o;
    end
  end
endmodule : dwe_arb_model
`default_nettype wire

/* File: test/data_write_envelope_order_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module data_write_envelope_order_bench import dwe_pkg::*;;
  logic mclk_i = 1'b0, rstn_i = 1'b0, data_retry_in_n_i = 1'b1;
  logic data_grant_in_i = 1'b0, write_first_qualifier_i = 1'b0;
  logic data_busy_in_i = 1'b0, agen = 1'b1, aretry = 1'b0;
  logic rd_req_i = 1'b0, wr_req_i = 1'b0, push_req_i = 1'b0;
  logic rd_burst_i = 1'b0, wr_burst_i = 1'b0, push_burst_i = 1'b0;
  logic [IDW-1:0] rd_id_i = 4'h0, wr_id_i = 4'h0, push_id_i = 4'h0;
  wire logic address_grant_in_i, addr_ack_i, address_retry_i;
  wire logic transfer_ack_i, taken;
  logic addr_busy_o, rd_taken_o, wr_taken_o, push_taken_o, wr_drive_o;
  logic data_busy_out_o, data_busy_oe_o, rd_latch_o;
  logic [IDW-1:0] addr_id_o, data_id_o;
  dwe_kind_e addr_kind_o;
  dwe_mode_e stream_mode_o;
  int fails = 0, check_count = 0;

  always #12.5 mclk_i = ~mclk_i;
  assign taken = rd_taken_o | wr_taken_o | push_taken_o;

  dwe_top dut (.mclk_i, .rstn_i, .data_retry_in_n_i, .address_grant_in_i,
    .addr_ack_i, .address_retry_i, .data_grant_in_i,
    .write_first_qualifier_i, .data_busy_in_i, .transfer_ack_i, .rd_req_i,
    .rd_id_i, .rd_burst_i, .wr_req_i, .wr_id_i, .wr_burst_i, .push_req_i,
    .push_id_i, .push_burst_i, .addr_busy_o, .addr_kind_o, .addr_id_o,
    .rd_taken_o, .wr_taken_o, .push_taken_o, .data_busy_out_o,
    .data_busy_oe_o, .wr_drive_o, .rd_latch_o, .data_id_o, .stream_mode_o);

  dwe_arb_model arb (.mclk_i, .rstn_i, .agen_i(agen), .retry_i(aretry),
    .addr_busy_i(addr_busy_o), .taken_i(taken),
    .data_busy_i(data_busy_out_o), .address_grant_o(address_grant_in_i),
    .addr_ack_o(addr_ack_i), .address_retry_o(address_retry_i),
    .transfer_ack_o(transfer_ack_i));

  //----------------------------------------
  // Shared tasks
  //----------------------------------------
  task automatic print_verdict();
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic do_reset(input logic strap_n, input dwe_mode_e m);
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    data_retry_in_n_i <= strap_n;
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    data_retry_in_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    chk("mode", m, stream_mode_o);
    chk("idle busy", 0, data_busy_out_o);
  endtask : do_reset

  task automatic addr_op(input dwe_kind_e k, logic [IDW-1:0] id,
                         input logic b, rty);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(posedge mclk_i);
    aretry <= rty;
    if (k == K_READ) {rd_req_i, rd_id_i, rd_burst_i} <= {1'b1, id, b};
    if (k == K_WRITE) {wr_req_i, wr_id_i, wr_burst_i} <= {1'b1, id, b};
    if (k == K_PUSH) {push_req_i, push_id_i, push_burst_i} <= {1'b1, id, b};
    if (rty) begin
      while (addr_ack_i !== 1'b1 && n < 40) begin
        @(posedge mclk_i);
        #1;
        n++;
      end
      @(posedge mclk_i);
      aretry <= 1'b0;
      @(posedge mclk_i);
      #1;
      chk("retried taken", 0, taken);
    end
    while (!seen && n < 60) begin
      @(posedge mclk_i);
      #1;
      n++;
      if (addr_busy_o === 1'b1) begin
        chk("addr kind", k, addr_kind_o);
        chk("addr id", id, addr_id_o);
      end
      seen = (k == K_READ) ? rd_taken_o === 1'b1 :
             (k == K_WRITE) ? wr_taken_o === 1'b1 : push_taken_o === 1'b1;
    end
    chk("addr taken", 1, seen);
    chk("addr busy end", 0, addr_busy_o);
    if (!seen) print_verdict();
    @(posedge mclk_i);
    if (k == K_READ) rd_req_i <= 1'b0;
    if (k == K_WRITE) wr_req_i <= 1'b0;
    if (k == K_PUSH) push_req_i <= 1'b0;
  endtask : addr_op

  task automatic data_op(input logic wf, wr, logic [IDW-1:0] id,
                         input int beats);
    int n, lat;
    n = 0;
    lat = 0;
    @(posedge mclk_i);
    data_grant_in_i <= 1'b1;
    write_first_qualifier_i <= wf;
    @(posedge mclk_i);
    data_grant_in_i <= 1'b0;
    write_first_qualifier_i <= 1'b0;
    #1;
    chk("data busy", 1, data_busy_out_o);
    chk("busy enable", 1, data_busy_oe_o);
    chk("write drive", wr, wr_drive_o);
    chk("data id", id, data_id_o);
    while (data_busy_out_o === 1'b1 && n < 40) begin
      @(posedge mclk_i);
      #1;
      n++;
      lat = lat + int'(rd_latch_o === 1'b1);
    end
    chk("busy cycles", 8'(2 * beats), 8'(n));
    chk("read latches", wr ? 8'h00 : 8'(beats), 8'(lat));
    if (n >= 40) print_verdict();
  endtask : data_op

  //----------------------------------------
  // Scenarios
  //----------------------------------------
  task automatic s_order();
    @(posedge mclk_i);
    data_retry_in_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    data_retry_in_n_i <= 1'b1;
    #1;
    chk("mode after strap", MODE_NORMAL, stream_mode_o);
    addr_op(K_READ, 4'h1, 1'b0, 1'b1);
    addr_op(K_WRITE, 4'h2, 1'b0, 1'b0);
    data_busy_in_i <= 1'b1;
    data_grant_in_i <= 1'b1;
    @(posedge mclk_i);
    data_grant_in_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    data_busy_in_i <= 1'b0;
    #1;
    chk("blocked grant", 0, data_busy_out_o);
    data_op(1'b0, 1'b0, 4'h1, 1);
    data_op(1'b0, 1'b1, 4'h2, 1);
  endtask : s_order

  task automatic s_envelope();
    addr_op(K_READ, 4'h3, 1'b1, 1'b0);
    addr_op(K_WRITE, 4'h4, 1'b1, 1'b0);
    addr_op(K_WRITE, 4'h5, 1'b0, 1'b0);
    repeat (5) @(posedge mclk_i);
    data_op(1'b1, 1'b1, 4'h4, 4);
    data_op(1'b1, 1'b1, 4'h5, 1);
    data_op(1'b0, 1'b0, 4'h3, 4);
  endtask : s_envelope

  task automatic s_nopend();
    addr_op(K_WRITE, 4'h6, 1'b0, 1'b0);
    addr_op(K_WRITE, 4'h7, 1'b1, 1'b0);
    data_op(1'b1, 1'b1, 4'h6, 1);
    data_op(1'b1, 1'b1, 4'h7, 4);
  endtask : s_nopend

  task automatic s_push();
    @(posedge mclk_i);
    agen <= 1'b0;
    // Grant still stands one edge after agen drops
    @(posedge mclk_i);
    {wr_req_i, wr_id_i, wr_burst_i} <= {1'b1, 4'h8, 1'b0};
    repeat (3) @(posedge mclk_i);
    agen <= 1'b1;
    addr_op(K_PUSH, 4'h9, 1'b0, 1'b0);
    addr_op(K_WRITE, 4'h8, 1'b0, 1'b0);
    data_op(1'b0, 1'b1, 4'h9, 1);
    data_op(1'b0, 1'b1, 4'h8, 1);
  endtask : s_push

  task automatic s_stream();
    do_reset(1'b0, MODE_STREAM);
    @(posedge mclk_i);
    data_busy_in_i <= 1'b1;
    addr_op(K_READ, 4'hA, 1'b1, 1'b0);
    data_op(1'b0, 1'b0, 4'hA, 4);
    @(posedge mclk_i);
    data_busy_in_i <= 1'b0;
    #1;
    chk("mode held", MODE_STREAM, stream_mode_o);
  endtask : s_stream

  initial begin
    do_reset(1'b1, MODE_NORMAL);
    s_order();
    s_envelope();
    s_nopend();
    s_push();
    s_stream();
    print_verdict();
  end
endmodule : data_write_envelope_order_bench
`default_nettype wire
